// ===== ecs_core.sv
`timescale 1ns/100ps
// Contract
// [RQ1] no fault gives status 00h
// [RQ2] bad checksum rejects frame, code 0Ah
// [RQ3] wrong byte count rejects, code 0Ch
// [RQ4] illegal argument rejects, code 0Dh
// [RQ5] store to read-only field refused, 0Eh
// [RQ6] resizing fixed field refused, code 10h
// [RQ7] word address past field end, 11h
// [RQ8] missing data field refused, code 12h
// [RQ9] supervisor restart shows 07h until read
// [RQ10] overspeed flags 1Fh, no trusted position
// [RQ11] destroyed partition table at init, 03h
// [RQ12] internal bus failure at init, 05h
// [RQ13] analog window violation raises 1Ch
// [RQ14] emitter current or RAM fault, 1Dh
// [RQ15] protected commands execute only with key
// [RQ16] key resets to factory value 55h
// [RQ17] serial number and version query
// [RQ18] data field status query
// [RQ19] unknown command ignored, answered 0Bh
module ecs_core
  import ecs_pkg::*;
#(
  parameter logic [7:0] MODEL_ID = 8'h3A, // arbitrary value
  parameter logic [31:0] SERIAL_NO = 32'h0000_1234, // arbitrary value
  parameter logic [7:0] FW_VERSION = 8'h01 // arbitrary value
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // received frame bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // reply bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  // on-chip monitors
  input wire logic [26:0] raw_pos,
  input wire logic [7:0] temp_c,
  input wire logic init_done,
  input wire logic wdog_restart,
  input wire logic part_bad,
  input wire logic i2c_fail,
  input wire logic ana_bad,
  input wire logic emit_bad,
  input wire logic overspeed,
  // visible state
  output logic [7:0] status_code,
  output logic [7:0] link_mode
);
  ecs_state_type state;
  logic [7:0] rb [0:FRAME_MAX-1];
  logic [3:0] rcnt;
  logic overrun;
  logic [7:0] rsum;
  logic [7:0] dev_addr;
  logic [7:0] key;
  logic [7:0] last_err;
  logic wdog_flag;
  logic part_flag;
  logic i2c_flag;
  logic [26:0] pos_ofs;
  logic [15:0] counter;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [5:0] fsize [0:FIELD_CNT-1];
  logic [3:0] fexist;
  logic [3:0] fwr;
  logic [3:0] ffix;
  // slot 7 is spare so the index stays in range once a short reply has run out
  logic [7:0] rep [0:7];
  logic [2:0] rep_len;
  logic [2:0] tidx;
  logic [7:0] tsum;
  logic [7:0] cmd;
  logic [3:0] nargs;
  logic [1:0] fld;
  logic [6:0] mptr;
  logic drop;
  logic csum_bad;
  logic unknown;
  logic ex;
  logic ok_ex;
  logic status_rd;
  logic [7:0] next_err;
  logic [7:0] next_status;
  logic [7:0] free_bytes;
  logic [26:0] pos_now;

  assign cmd = rb[1];
  assign nargs = rcnt - FRAME_OVH;
  assign fld = rb[2][1:0];
  assign mptr = {fld, rb[3][4:0]};
  assign csum_bad = rsum != 8'h00; // [RQ2]
  assign unknown = cmd_args(cmd) == ARGS_NONE;
  // frames for another address are dropped silently, no reply
  assign drop = rcnt < FRAME_OVH || !(rb[0] == dev_addr || rb[0] == BCAST_ADDR);
  assign ex = state == ST_EXEC && !drop;
  assign ok_ex = ex && next_err == ST_OK;
  assign status_rd = ok_ex && cmd == CMD_STATUS;
  assign pos_now = raw_pos + pos_ofs;

  always_comb
  begin
    free_bytes = MEM_BYTES;
    for (int i = 0; i < 4; i++)
    begin
      if (fexist[i])
        free_bytes = free_bytes - {2'h0, fsize[i]};
    end
  end

  // hardware faults outrank the last command error
  always_comb
  begin
    if (wdog_flag)
      next_status = ST_WDOG; // [RQ9]
    else if (part_flag)
      next_status = ST_PART; // [RQ11]
    else if (i2c_flag)
      next_status = ST_I2C; // [RQ12]
    else if (overspeed)
      next_status = ST_OVSPD; // [RQ10]
    else if (ana_bad)
      next_status = ST_ANA; // [RQ13]
    else if (emit_bad)
      next_status = ST_EMIT; // [RQ14]
    else
      next_status = last_err; // [RQ1]
  end

  always_comb
  begin
    next_err = ST_OK;
    if (csum_bad)
      next_err = ST_CSUM; // [RQ2]
    else if (unknown)
      next_err = ST_UNK; // [RQ19]
    else if (overrun || nargs != cmd_args(cmd))
      next_err = ST_LEN; // [RQ3]
    else
    begin
      case (cmd)
        CMD_RD_POS:
          if (overspeed)
            next_err = ST_OVSPD; // [RQ10]
        CMD_SET_POS:
          if (rb[6] != key)
            next_err = ST_KEY; // [RQ15]
        CMD_RD_ANA:
          if (rb[2] != ANA_CH_TEMP)
            next_err = ST_ARG; // [RQ4]
        CMD_NEW_KEY, CMD_SET_ADDR:
          if ((cmd == CMD_NEW_KEY ? rb[2] : rb[3]) != key)
            next_err = ST_KEY; // [RQ15]
        CMD_CFG:
          if (rb[3] != key)
            next_err = ST_KEY; // [RQ15]
          else if (rb[2][7:4] != MODE_HI)
            next_err = ST_ARG; // [RQ4]
        CMD_RD_DATA, CMD_ST_DATA, CMD_FLD_STAT, CMD_MK_FLD:
          if (rb[2] >= FIELD_CNT || (cmd != CMD_MK_FLD && !fexist[fld]))
            next_err = ST_NOFLD; // [RQ8]
          else if (cmd == CMD_MK_FLD && ffix[fld])
            next_err = ST_SIZE; // [RQ6]
          else if (cmd == CMD_MK_FLD && (rb[3] == 8'h00 || rb[3] > FLD_BYTES))
            next_err = ST_ARG; // [RQ4]
          else if (cmd != CMD_FLD_STAT && cmd != CMD_MK_FLD && rb[3] >= {2'h0, fsize[fld]})
            next_err = ST_ADDR; // [RQ7]
          else if (cmd == CMD_ST_DATA && !fwr[fld])
            next_err = ST_WPROT; // [RQ5]
        default: next_err = ST_OK;
      endcase
    end
  end

  // frame collection and sequencing; no new frame is taken while replying
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      rcnt <= 4'h0;
      overrun <= 1'b0;
      rsum <= 8'h00;
      tidx <= 3'h0;
      for (int i = 0; i < 8; i++)
        rb[i] <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE, ST_RECV:
          if (rx_valid)
          begin
            if (rcnt < FRAME_MAX)
              rb[rcnt[2:0]] <= rx_data;
            overrun <= overrun | (rcnt >= FRAME_MAX); // [RQ3]
            rcnt <= (rcnt == 4'hF) ? rcnt : rcnt + 4'h1;
            rsum <= rsum ^ rx_data;
            state <= rx_last ? ST_EXEC : ST_RECV;
          end
        ST_EXEC:
        begin
          state <= drop ? ST_IDLE : ST_SEND;
          rcnt <= 4'h0;
          overrun <= 1'b0;
          rsum <= 8'h00;
          tidx <= 3'h0;
        end
        ST_SEND:
        begin
          tidx <= tidx + 3'h1;
          if (tidx == rep_len)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // persistent settings change only on a fully accepted command
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dev_addr <= ADDR_RST;
      key <= KEY_RST; // [RQ16]
      link_mode <= MODE_RST;
      pos_ofs <= 27'h0;
      counter <= 16'h0;
    end
    else if (ok_ex)
    begin
      case (cmd)
        CMD_SET_POS: pos_ofs <= {rb[2][2:0], rb[3], rb[4], rb[5]} - raw_pos; // [RQ15]
        CMD_INC_CNT: counter <= counter + 16'h1;
        CMD_CLR_CNT: counter <= 16'h0;
        CMD_NEW_KEY: key <= rb[3];
        CMD_SET_ADDR: dev_addr <= rb[2]; // [RQ15]
        CMD_CFG: link_mode <= rb[2]; // [RQ15]
        default: counter <= counter;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fexist <= FLD_RST_EXIST;
      fwr <= FLD_RST_WR;
      ffix <= FLD_RST_FIX;
      for (int i = 0; i < 4; i++)
        fsize[i] <= FLD_RST_SIZE;
    end
    else if (ok_ex && cmd == CMD_MK_FLD)
    begin
      fexist[fld] <= 1'b1;
      fwr[fld] <= 1'b1;
      fsize[fld] <= rb[3][5:0];
    end
  end

  // data memory is not reset, it models the field storage
  always_ff @(posedge ref_clk)
  begin
    if (ok_ex && cmd == CMD_ST_DATA)
      mem[mptr] <= rb[4]; // [RQ5]
  end

  // set beats clear: a restart in the read cycle stays latched
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wdog_flag <= 1'b0;
      part_flag <= 1'b0;
      i2c_flag <= 1'b0;
      last_err <= ST_OK;
      status_code <= ST_OK;
    end
    else
    begin
      wdog_flag <= wdog_restart | (wdog_flag & !status_rd & !(ok_ex && cmd == CMD_RESET)); // [RQ9]
      part_flag <= (!init_done & part_bad) | (part_flag & !(ok_ex && cmd == CMD_RESET)); // [RQ11]
      i2c_flag <= (!init_done & i2c_fail) | (i2c_flag & !(ok_ex && cmd == CMD_RESET)); // [RQ12]
      if (ex && next_err != ST_OK)
        last_err <= next_err;
      else if (status_rd || (ok_ex && cmd == CMD_RESET))
        last_err <= ST_OK;
      status_code <= next_status;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rep_len <= 3'h2;
      for (int i = 0; i < 8; i++)
        rep[i] <= 8'h00;
    end
    else if (ex)
    begin
      rep[0] <= dev_addr;
      rep[1] <= (next_err != ST_OK) ? (cmd | ERR_FLAG) : cmd;
      rep_len <= 3'h2;
      if (next_err != ST_OK)
      begin
        rep[2] <= next_err;
        rep_len <= 3'h3;
      end
      else
      begin
        case (cmd)
          CMD_RD_POS:
          begin
            {rep[2], rep[3], rep[4], rep[5]} <= {5'h0, pos_now};
            rep_len <= 3'h6;
          end
          CMD_RD_CNT:
          begin
            {rep[2], rep[3]} <= counter;
            rep_len <= 3'h4;
          end
          CMD_FLD_STAT:
          begin
            rep[2] <= {2'h0, fsize[fld]};
            rep[3] <= {6'h0, ffix[fld], fwr[fld]}; // [RQ18]
            rep_len <= 3'h4;
          end
          CMD_SERIAL:
          begin
            {rep[2], rep[3], rep[4], rep[5]} <= SERIAL_NO;
            rep[6] <= FW_VERSION; // [RQ17]
            rep_len <= 3'h7;
          end
          CMD_RD_ANA, CMD_RD_DATA, CMD_FREE, CMD_STATUS, CMD_TYPE:
          begin
            rep_len <= 3'h3;
            case (cmd)
              CMD_RD_ANA: rep[2] <= temp_c;
              CMD_RD_DATA: rep[2] <= mem[mptr];
              CMD_FREE: rep[2] <= free_bytes;
              CMD_STATUS: rep[2] <= next_status; // [RQ1]
              default: rep[2] <= MODEL_ID;
            endcase
          end
          default: rep_len <= 3'h2;
        endcase
      end
    end
  end

  // reply goes out one byte per cycle, closed by an xor checksum
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      tsum <= 8'h00;
    end
    else
    begin
      tx_valid <= state == ST_SEND;
      tx_last <= state == ST_SEND && tidx == rep_len;
      tx_data <= (tidx == rep_len) ? tsum : rep[tidx];
      if (state == ST_EXEC)
        tsum <= 8'h00;
      else if (state == ST_SEND && tidx != rep_len)
        tsum <= tsum ^ rep[tidx];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  csum_reject_a: assert property (ex && csum_bad |=> last_err == ST_CSUM) // [RQ2]
    else $error("bad checksum not reported");
  unknown_cmd_a: assert property (ex && !csum_bad && unknown // [RQ19]
    |=> last_err == ST_UNK && $stable(counter) && $stable(dev_addr) && $stable(key))
    else $error("unknown command changed state or code");
  len_reject_a: assert property (ex && !csum_bad && !unknown // [RQ3]
    && nargs != cmd_args(cmd) |=> last_err == ST_LEN)
    else $error("wrong length not reported");
  arg_reject_a: assert property (ex && !csum_bad && cmd == CMD_RD_ANA // [RQ4]
    && rcnt == 4'h4 && rb[2] != ANA_CH_TEMP |=> last_err == ST_ARG)
    else $error("illegal argument not reported");
  addr_key_a: assert property (ex && !csum_bad && cmd == CMD_SET_ADDR // [RQ15]
    && rcnt == 4'h5 && rb[3] != key |=> $stable(dev_addr) && last_err == ST_KEY)
    else $error("address changed without key");
  field_miss_a: assert property (ex && !csum_bad && cmd == CMD_FLD_STAT // [RQ8]
    && rcnt == 4'h4 && rb[2] >= FIELD_CNT |=> last_err == ST_NOFLD)
    else $error("missing field not reported");
  wdog_code_a: assert property (wdog_restart |=> ##1 status_code == ST_WDOG) // [RQ9]
    else $error("supervisor restart not shown");
  status_ok_a: assert property (ex && !csum_bad && cmd == CMD_STATUS // [RQ1]
    && rcnt == 4'h3 && next_status == ST_OK |=> rep[2] == ST_OK ##1 tx_valid)
    else $error("fault-free status not 00h");
  reply_len_a: assert property (ex |=> ##1 tx_valid [*3])
    else $error("reply shorter than three bytes");

  pos_read_c: cover property (ok_ex && cmd == CMD_RD_POS);
  key_fail_c: cover property (ex && next_err == ST_KEY);
  store_ok_c: cover property (ok_ex && cmd == CMD_ST_DATA ##[1:20] tx_last);
endmodule

// ===== ecs_core_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); err_total++; end end
module ecs_core_tb import ecs_pkg::*; ;
  localparam logic [7:0] MID = 8'h5C; // arbitrary value
  localparam logic [31:0] SER = 32'h1357_9BDF; // arbitrary value
  localparam logic [7:0] FWV = 8'h07; // arbitrary value
  logic ref_clk = 1'b0;
  logic rst, init_done, wdog_restart, tx_valid, tx_last, rx_valid, rx_last;
  logic [7:0] rx_data, tx_data, temp_c, status_code, link_mode;
  logic [26:0] raw_pos;
  logic [4:0] flt;
  logic [31:0] p;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [7:0] d8;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  always #4 ref_clk = ~ref_clk;

  ecs_ctrl_model ctrl (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last));
  ecs_core #(.MODEL_ID(MID), .SERIAL_NO(SER), .FW_VERSION(FWV)) uut (
    .ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .raw_pos(raw_pos),
    .temp_c(temp_c), .init_done(init_done), .wdog_restart(wdog_restart), .part_bad(flt[3]),
    .i2c_fail(flt[4]), .ana_bad(flt[0]), .emit_bad(flt[1]), .overspeed(flt[2]),
    .status_code(status_code), .link_mode(link_mode));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      $display("MISMATCH run_time expected below %0d seen %0d", 5000, cyc);
      err_total++;
      print_verdict();
    end
  end

  // reply bytes are taken off the note queue in order
  always @(posedge ref_clk)
  begin
    if (tx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        e = 'x;
      else
        e = exp_q.pop_front();
      `CHK("tx_data", e[7:0], tx_data)
      `CHK("tx_last", e[8], tx_last)
    end
  end

  task automatic xact(input logic [7:0] f[$], input logic [7:0] d[$], input logic [7:0] code,
      input bit bad = 1'b0);
    logic [7:0] r[$];
    logic [7:0] cs;
    int n;
    r = '{f[0], f[1]};
    if (code != ST_OK)
      r = '{f[0], f[1] | ERR_FLAG, code};
    else
      r = {r, d};
    cs = 8'h00;
    foreach (r[i]) cs ^= r[i];
    r.push_back(cs);
    foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    ctrl.send_frame(f, bad);
    n = 0;
    while (exp_q.size() != 0 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("reply_done", 1'b1, n < 40)
    if (n >= 40)
      exp_q.delete();
    @(posedge ref_clk);
  endtask

  task automatic st(input logic [7:0] ex);
    `CHK("status_code", ex, status_code)
  endtask

  // init faults latch only while init_done is low, so they pulse inside that gap
  task automatic fault(input int k, input logic [7:0] code);
    @(posedge ref_clk);
    flt[k] <= 1'b1;
    init_done <= (k < 3);
    @(posedge ref_clk);
    if (k >= 3)
      flt[k] <= 1'b0;
    init_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    st(code);
    flt <= '0;
    if (k >= 3)
      xact('{ADDR_RST, CMD_RESET}, '{}, ST_OK);
    else
      repeat (3) @(posedge ref_clk);
    st(ST_OK);
  endtask

  initial
  begin
    rst = 1'b1;
    init_done = 1'b1;
    wdog_restart = 1'b0;
    flt = '0;
    void'($urandom(32'hBAF5055E));
    raw_pos = 27'($urandom());
    temp_c = 8'($urandom());
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("link_mode", MODE_RST, link_mode)
    xact('{ADDR_RST, CMD_STATUS}, '{ST_OK}, ST_OK);
    xact('{ADDR_RST, CMD_STATUS}, '{}, ST_CSUM, 1'b1);
    xact('{ADDR_RST, CMD_STATUS}, '{ST_CSUM}, ST_OK);
    st(ST_OK);
    $display("test status_basic done");
    xact('{ADDR_RST, 8'h45}, '{}, ST_UNK);
    `CHK("link_mode", MODE_RST, link_mode)
    xact('{ADDR_RST, CMD_STATUS, 8'h01}, '{}, ST_LEN);
    xact('{ADDR_RST, CMD_RD_ANA, 8'h00}, '{}, ST_ARG);
    xact('{ADDR_RST, CMD_CFG, 8'h35, KEY_RST}, '{}, ST_ARG);
    xact('{ADDR_RST, CMD_ST_DATA, 8'h01, 8'h00, 8'h5A}, '{}, ST_WPROT);
    xact('{ADDR_RST, CMD_MK_FLD, 8'h01, 8'h08}, '{}, ST_SIZE);
    xact('{ADDR_RST, CMD_RD_DATA, 8'h00, 8'h10}, '{}, ST_ADDR);
    xact('{ADDR_RST, CMD_RD_DATA, 8'h02, 8'h00}, '{}, ST_NOFLD);
    xact('{ADDR_RST, CMD_FLD_STAT, 8'h07}, '{}, ST_NOFLD);
    // more than eight frame bytes overruns the buffer
    xact('{ADDR_RST, CMD_STATUS, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07}, '{},
      ST_LEN);
    xact('{ADDR_RST, CMD_SET_ADDR, 8'h41, 8'h54}, '{}, ST_KEY);
    xact('{ADDR_RST, CMD_SET_POS, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA}, '{}, ST_KEY);
    st(ST_KEY);
    xact('{ADDR_RST, CMD_STATUS}, '{ST_KEY}, ST_OK);
    $display("test command_errors done");
    xact('{ADDR_RST, CMD_CFG, 8'hE5, KEY_RST}, '{}, ST_OK);
    `CHK("link_mode", 8'hE5, link_mode)
    xact('{ADDR_RST, CMD_FLD_STAT, 8'h01}, '{{2'b00, FLD_RST_SIZE}, 8'h02}, ST_OK);
    xact('{ADDR_RST, CMD_SERIAL}, '{SER[31:24], SER[23:16], SER[15:8], SER[7:0], FWV},
      ST_OK);
    xact('{ADDR_RST, CMD_TYPE}, '{MID}, ST_OK);
    xact('{ADDR_RST, CMD_RD_ANA, ANA_CH_TEMP}, '{temp_c}, ST_OK);
    d8 = 8'($urandom());
    xact('{ADDR_RST, CMD_ST_DATA, 8'h00, 8'h03, d8}, '{}, ST_OK);
    xact('{ADDR_RST, CMD_RD_DATA, 8'h00, 8'h03}, '{d8}, ST_OK);
    xact('{ADDR_RST, CMD_MK_FLD, 8'h02, 8'h08}, '{}, ST_OK);
    xact('{ADDR_RST, CMD_FLD_STAT, 8'h02}, '{8'h08, 8'h01}, ST_OK);
    xact('{ADDR_RST, CMD_FREE}, '{8'(MEM_BYTES - 2 * FLD_RST_SIZE - 8)}, ST_OK);
    xact('{ADDR_RST, CMD_INC_CNT}, '{}, ST_OK);
    xact('{ADDR_RST, CMD_INC_CNT}, '{}, ST_OK);
    // a frame for another address gets no reply and must not clear the counter
    ctrl.send_frame('{8'h3B, CMD_CLR_CNT}, 1'b0);
    repeat (12) @(posedge ref_clk);
    xact('{ADDR_RST, CMD_RD_CNT}, '{8'h00, 8'h02}, ST_OK);
    xact('{ADDR_RST, CMD_CLR_CNT}, '{}, ST_OK);
    xact('{ADDR_RST, CMD_RD_CNT}, '{8'h00, 8'h00}, ST_OK);
    $display("test storage done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      raw_pos <= 27'($urandom());
      @(posedge ref_clk);
      p = {5'h00, raw_pos};
      xact('{ADDR_RST, CMD_RD_POS}, '{p[31:24], p[23:16], p[15:8], p[7:0]}, ST_OK);
    end
    p = {5'h00, 27'($urandom())};
    xact('{ADDR_RST, CMD_SET_POS, p[31:24], p[23:16], p[15:8], p[7:0], KEY_RST}, '{},
      ST_OK);
    xact('{ADDR_RST, CMD_RD_POS}, '{p[31:24], p[23:16], p[15:8], p[7:0]}, ST_OK);
    $display("test queries done");
    flt[2] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    st(ST_OVSPD);
    xact('{ADDR_RST, CMD_RD_POS}, '{}, ST_OVSPD);
    flt[2] <= 1'b0;
    xact('{ADDR_RST, CMD_STATUS}, '{ST_OVSPD}, ST_OK);
    fault(0, ST_ANA);
    fault(1, ST_EMIT);
    fault(3, ST_PART);
    fault(4, ST_I2C);
    $display("test monitors done");
    wdog_restart <= 1'b1;
    @(posedge ref_clk);
    wdog_restart <= 1'b0;
    repeat (20) @(posedge ref_clk);
    st(ST_WDOG);
    xact('{ADDR_RST, CMD_STATUS}, '{ST_WDOG}, ST_OK);
    st(ST_OK);
    $display("test supervisor done");
    xact('{ADDR_RST, CMD_NEW_KEY, KEY_RST, 8'h3C}, '{}, ST_OK);
    xact('{ADDR_RST, CMD_SET_ADDR, 8'h41, 8'h3C}, '{}, ST_OK);
    xact('{8'h41, CMD_TYPE}, '{MID}, ST_OK);
    // a mid-run reset must bring back address, key and mode
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("link_mode", MODE_RST, link_mode)
    st(ST_OK);
    xact('{ADDR_RST, CMD_CFG, 8'hE6, KEY_RST}, '{}, ST_OK);
    `CHK("link_mode", 8'hE6, link_mode)
    $display("test reset done");
    print_verdict();
  end
endmodule

// ===== ecs_ctrl_model.sv
`timescale 1ns/100ps
module ecs_ctrl_model
(
  // clock
  input wire logic ref_clk,
  // frame bytes toward the encoder
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_last = 1'b0;
  end

  // bytes go out back to back; the checksum byte closes the frame
  task automatic send_frame(input logic [7:0] b[$], input bit bad);
    logic [7:0] cs;
    cs = 8'h00;
    foreach (b[i])
    begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= b[i];
      cs = cs ^ b[i];
    end
    @(posedge ref_clk);
    rx_data <= bad ? ~cs : cs;
    rx_last <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // released line shows the inverse so a stale byte cannot pass as data
    rx_data <= bad ? cs : ~cs;
  endtask
endmodule

// ===== ecs_pkg.sv
package ecs_pkg;
  // command bytes
  localparam logic [7:0] CMD_RD_POS = 8'h42;
  localparam logic [7:0] CMD_SET_POS = 8'h43;
  localparam logic [7:0] CMD_RD_ANA = 8'h44;
  localparam logic [7:0] CMD_RD_CNT = 8'h46;
  localparam logic [7:0] CMD_INC_CNT = 8'h47;
  localparam logic [7:0] CMD_CLR_CNT = 8'h49;
  localparam logic [7:0] CMD_RD_DATA = 8'h4A;
  localparam logic [7:0] CMD_ST_DATA = 8'h4B;
  localparam logic [7:0] CMD_FLD_STAT = 8'h4C;
  localparam logic [7:0] CMD_MK_FLD = 8'h4D;
  localparam logic [7:0] CMD_FREE = 8'h4E;
  localparam logic [7:0] CMD_NEW_KEY = 8'h4F;
  localparam logic [7:0] CMD_STATUS = 8'h50;
  localparam logic [7:0] CMD_TYPE = 8'h52;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_SET_ADDR = 8'h55;
  localparam logic [7:0] CMD_SERIAL = 8'h56;
  localparam logic [7:0] CMD_CFG = 8'h57;
  // status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_PART = 8'h03;
  localparam logic [7:0] ST_I2C = 8'h05;
  localparam logic [7:0] ST_WDOG = 8'h07;
  localparam logic [7:0] ST_CSUM = 8'h0A;
  localparam logic [7:0] ST_UNK = 8'h0B;
  localparam logic [7:0] ST_LEN = 8'h0C;
  localparam logic [7:0] ST_ARG = 8'h0D;
  localparam logic [7:0] ST_WPROT = 8'h0E;
  localparam logic [7:0] ST_KEY = 8'h0F;
  localparam logic [7:0] ST_SIZE = 8'h10;
  localparam logic [7:0] ST_ADDR = 8'h11;
  localparam logic [7:0] ST_NOFLD = 8'h12;
  localparam logic [7:0] ST_ANA = 8'h1C;
  localparam logic [7:0] ST_EMIT = 8'h1D;
  localparam logic [7:0] ST_OVSPD = 8'h1F;
  // reset values and constants
  localparam logic [7:0] ADDR_RST = 8'h40;
  localparam logic [7:0] MODE_RST = 8'hE4;
  localparam logic [7:0] KEY_RST = 8'h55;
  localparam logic [7:0] BCAST_ADDR = 8'hFF;
  localparam logic [7:0] ERR_FLAG = 8'h80;
  localparam logic [7:0] ANA_CH_TEMP = 8'h48;
  localparam logic [3:0] MODE_HI = 4'hE;
  localparam logic [3:0] ARGS_NONE = 4'hF;
  localparam logic [3:0] FRAME_MAX = 4'h8;
  localparam logic [3:0] FRAME_OVH = 4'h3;
  localparam logic [7:0] FIELD_CNT = 8'h04;
  localparam logic [7:0] FLD_BYTES = 8'h20;
  localparam logic [7:0] MEM_BYTES = 8'h80;
  localparam logic [5:0] FLD_RST_SIZE = 6'h10;
  localparam logic [3:0] FLD_RST_EXIST = 4'h3;
  localparam logic [3:0] FLD_RST_WR = 4'h1;
  localparam logic [3:0] FLD_RST_FIX = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RECV = 2'h1,
    ST_EXEC = 2'h3,
    ST_SEND = 2'h2
  } ecs_state_type;

  // argument bytes each command needs; ARGS_NONE marks an unsupported code
  function automatic logic [3:0] cmd_args(input logic [7:0] c);
    case (c)
      CMD_RD_POS, CMD_RD_CNT, CMD_INC_CNT, CMD_CLR_CNT, CMD_FREE, CMD_STATUS,
      CMD_TYPE, CMD_RESET, CMD_SERIAL: cmd_args = 4'h0;
      CMD_RD_ANA, CMD_FLD_STAT: cmd_args = 4'h1;
      CMD_RD_DATA, CMD_MK_FLD, CMD_NEW_KEY, CMD_SET_ADDR, CMD_CFG: cmd_args = 4'h2;
      CMD_ST_DATA: cmd_args = 4'h3;
      CMD_SET_POS: cmd_args = 4'h5;
      default: cmd_args = ARGS_NONE;
    endcase
  endfunction
endpackage
